// file: hw/upc_pkg.sv
// upc_pkg: shared constants, enums and carrier structs of the periodic host channel
// assumes one 100 MHz core clock and a classic wishbone register port
package upc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CHAR = 8'h00; // channel_characteristics
  localparam logic [7:0] ADDR_TSIZ = 8'h04; // channel_transfer_size
  localparam logic [7:0] ADDR_INT = 8'h08; // channel flags, write one to clear
  localparam logic [7:0] ADDR_GSTS = 8'h0c; // global_interrupt_status
  localparam logic [7:0] ADDR_TXD = 8'h10; // transmit fifo push
  localparam logic [7:0] ADDR_RXSTS = 8'h14; // status entry pop
  localparam logic [7:0] ADDR_RXD = 8'h18; // receive fifo pop
  // channel_characteristics fields
  localparam int CHAR_ODD = 0; // odd_frame_select
  localparam int CHAR_ENA = 1; // channel_enable_bit
  localparam int CHAR_DIS = 2; // write one to halt the channel
  localparam int CHAR_DIR_IN = 3; // 1 = periodic in channel
  localparam int CHAR_MC_LSB = 4; // multi_count_field, two bits
  // channel_transfer_size fields
  localparam int TSIZ_WPP_LSB = 16; // words per packet, eight bits
  // flag positions
  localparam int INT_TRANSFER_COMPLETE_FLAG = 0; // transfer_complete_flag
  localparam int INT_HALT = 1; // channel_halted_flag
  localparam int INT_ACK = 2;
  localparam int INT_NAK = 3;
  localparam int INT_STALL = 4;
  localparam int INT_XERR = 5; // transaction_error_flag
  localparam int INT_BBL = 6; // babble_error_flag
  localparam int INT_FOVR = 7; // frame_overrun_flag
  // global status positions
  localparam int GSTS_RXLVL = 0; // rx_fifo_level_flag
  localparam int GSTS_TXEMP = 1; // tx_fifo_empty_status
  localparam int GSTS_ODD = 2; // current frame is odd
  localparam int GSTS_PQ_LSB = 4; // periodic queue fill, three bits
  // packet_status_code values
  localparam logic [15:0] STS_IN_DATA = 16'h0010;
  localparam logic [15:0] STS_XFER_DONE = 16'h0030;
  localparam logic [15:0] STS_HALT = 16'h0070;
  // depths and reset values
  localparam logic [2:0] PQ_DEPTH = 3'h4; // periodic request queue entries
  localparam logic [2:0] SQ_DEPTH = 3'h4; // status entries held
  localparam int MEM_AW = 8; // fifo words = 2**MEM_AW
  localparam logic [7:0] WPP_RST = 8'h01;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0004;

  // link handshake codes
  typedef enum logic [2:0] {
    HS_ACK = 3'b000,
    HS_NAK = 3'b001,
    HS_STALL = 3'b010,
    HS_XERR = 3'b011,
    HS_BBL = 3'b100
  } upc_hs_t;

  // channel sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } upc_st_t;

  // from the link engine
  typedef struct packed {
    logic hs_valid;
    upc_hs_t hs;
    logic rx_valid;
    logic rx_last;
    logic [31:0] rx_data;
  } upc_link_in_t;

  // to the link engine
  typedef struct packed {
    logic tok_req;
    logic tok_in;
    logic tx_valid;
    logic tx_last;
    logic [31:0] tx_data;
  } upc_link_out_t;

  // whole state of the channel
  typedef struct packed {
    logic wb_ack;
    logic wb_busy;
    logic [31:0] wb_dat;
    logic odd_sel;
    logic ch_ena;
    logic dir_in;
    logic [1:0] mc;
    logic [9:0] pkt_cnt;
    logic [7:0] wpp;
    logic [7:0] flags;
    logic frame_odd;
    logic sent_frame;
    logic [2:0] pq_cnt;
    upc_st_t st;
    logic tok_req;
    logic tok_in;
    logic [7:0] tx_wr_ptr;
    logic [7:0] tx_rd_ptr;
    logic [8:0] tx_cnt;
    logic [7:0] tx_word;
    logic [7:0] tx_left;
    logic tx_vld;
    logic tx_last;
    logic [7:0] rx_wr_ptr;
    logic [7:0] rx_rd_ptr;
    logic [8:0] rx_cnt;
    logic [15:0] rx_bytes;
    logic rx_unread;
    logic [3:0][31:0] sq;
    logic [2:0] sq_cnt;
    logic rx_lvl;
  } upc_state_t;

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] upc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : upc_merge
endpackage : upc_pkg

// file: hw/upc_mem.sv
// upc_mem: simple dual-port word memory with registered read data
// assumes one writer and one reader on the same clock
`timescale 1ns/1ps
module upc_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1]; // storage, no reset needed

  // write port
  always_ff @(posedge i_core_clk)
  begin
    if (i_clk_en && i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= '0;
    end
    else if (i_clk_en && i_re)
    begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : upc_mem

// file: hw/upc_chan.sv
// upc_chan: periodic host channel with wishbone registers and link engine port
// assumes link engine runs on i_core_clk and frames start with i_sof pulses
//
// Contract
// - last word of out packet posts request
// - out token goes out in odd frame
// - last acked out packet raises transfer complete
// - each in channel enable posts request
// - in token goes out in odd frame
// - stored in packet raises rx level flag
// - complete entry raises level; driver skips others
// - transfer complete after in packet read out
// - halted flag only after halt entry read
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module upc_chan (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic i_sof,
  input wire upc_pkg::upc_link_in_t i_link,
  output upc_pkg::upc_link_out_t o_link,
  output logic o_rx_fifo_level
);
  upc_pkg::upc_state_t s; // registered state
  upc_pkg::upc_state_t n; // next state
  logic req; // live bus request
  logic tx_re; // transmit memory read strobe
  logic rx_re; // receive memory read strobe
  logic tx_we; // transmit memory write strobe
  logic rx_we; // receive memory write strobe
  logic [31:0] tx_q; // transmit word out
  logic [31:0] rx_q; // receive word out
  logic [31:0] wreg; // merged register write
  logic post_out; // out packet completed in fifo
  logic post_in; // in request from enable write
  logic tok_fire; // token issued this cycle
  logic halt_push; // halt entry to queue
  logic halt_pop; // halt entry popped by software
  logic in_push; // in data entry to queue
  logic done_push; // transfer complete entry to queue

  // readback view of channel_characteristics
  function automatic logic [31:0] char_view(input upc_pkg::upc_state_t st);
    logic [31:0] r;
    r = '0;
    r[upc_pkg::CHAR_ODD] = st.odd_sel;
    r[upc_pkg::CHAR_ENA] = st.ch_ena;
    r[upc_pkg::CHAR_DIR_IN] = st.dir_in;
    r[upc_pkg::CHAR_MC_LSB +: 2] = st.mc;
    return r;
  endfunction : char_view

  // append one status entry, dropped when the queue is full
  function automatic upc_pkg::upc_state_t sq_push(input upc_pkg::upc_state_t st,
                                                  input logic [31:0] e);
    upc_pkg::upc_state_t r;
    r = st;
    if (st.sq_cnt != upc_pkg::SQ_DEPTH)
    begin
      r.sq[st.sq_cnt[1:0]] = e;
      r.sq_cnt = st.sq_cnt + 3'h1;
    end
    return r;
  endfunction : sq_push

  assign req = i_wb_cyc && i_wb_stb && !s.wb_ack;

  // next-state logic: bus slave, scheduler, link results
  always_comb
  begin
    n = s;
    tx_re = 1'b0;
    rx_re = 1'b0;
    tx_we = 1'b0;
    rx_we = 1'b0;
    wreg = '0;
    post_out = 1'b0;
    post_in = 1'b0;
    tok_fire = 1'b0;
    halt_push = 1'b0;
    halt_pop = 1'b0;
    in_push = 1'b0;
    done_push = 1'b0;
    n.wb_ack = 1'b0;
    n.tok_req = 1'b0;
    n.tx_vld = 1'b0;
    n.tx_last = 1'b0;
    // first bus cycle: latch, prefetch receive word
    if (req && !s.wb_busy)
    begin
      n.wb_busy = 1'b1;
      rx_re = !i_wb_we && (i_wb_adr == upc_pkg::ADDR_RXD);
    end
    // second bus cycle: access and ack together
    else if (req)
    begin
      n.wb_busy = 1'b0;
      n.wb_ack = 1'b1;
      n.wb_dat = '0;
      if (i_wb_we)
      begin
        case (i_wb_adr)
          upc_pkg::ADDR_CHAR:
          begin
            wreg = upc_pkg::upc_merge(char_view(s), i_wb_dat, i_wb_sel);
            n.odd_sel = wreg[upc_pkg::CHAR_ODD];
            n.dir_in = wreg[upc_pkg::CHAR_DIR_IN];
            n.mc = wreg[upc_pkg::CHAR_MC_LSB +: 2];
            n.ch_ena = wreg[upc_pkg::CHAR_ENA];
            // an enable write of an in channel queues one request unless it also sets the halt bit or the queue is full
            post_in = wreg[upc_pkg::CHAR_ENA] && wreg[upc_pkg::CHAR_DIR_IN]
                      && !wreg[upc_pkg::CHAR_DIS] && (s.pq_cnt != upc_pkg::PQ_DEPTH);
            // halt: flush queued requests, report through the status queue
            if (wreg[upc_pkg::CHAR_DIS])
            begin
              n.ch_ena = 1'b0;
              n.pq_cnt = '0;
              n.st = upc_pkg::ST_IDLE;
              halt_push = 1'b1;
            end
          end
          upc_pkg::ADDR_TSIZ:
          begin
            wreg = upc_pkg::upc_merge({8'h00, s.wpp, 6'h00, s.pkt_cnt}, i_wb_dat, i_wb_sel);
            n.pkt_cnt = wreg[9:0];
            n.wpp = wreg[upc_pkg::TSIZ_WPP_LSB +: 8];
          end
          upc_pkg::ADDR_INT:
          begin
            wreg = upc_pkg::upc_merge(32'h0, i_wb_dat, i_wb_sel);
            n.flags = s.flags & ~wreg[7:0]; // sets below win over this clear
          end
          upc_pkg::ADDR_TXD:
          begin
            // full words only; a full fifo drops the word
            if (i_wb_sel == 4'hf && !s.tx_cnt[8])
            begin
              tx_we = 1'b1;
              n.tx_wr_ptr = s.tx_wr_ptr + 8'h01;
              n.tx_cnt = s.tx_cnt + 9'h001;
              n.tx_word = s.tx_word + 8'h01;
              if (s.tx_word == s.wpp - 8'h01)
              begin
                n.tx_word = '0;
                post_out = !s.dir_in && (s.pq_cnt != upc_pkg::PQ_DEPTH);
              end
            end
          end
          default:
          begin
            n.wb_dat = '0; // unmapped and read-only: write ignored
          end
        endcase
      end
      else
      begin
        case (i_wb_adr)
          upc_pkg::ADDR_CHAR: n.wb_dat = char_view(s);
          upc_pkg::ADDR_TSIZ: n.wb_dat = {8'h00, s.wpp, 6'h00, s.pkt_cnt};
          upc_pkg::ADDR_INT: n.wb_dat = {24'h0, s.flags};
          upc_pkg::ADDR_GSTS: n.wb_dat = {25'h0, s.pq_cnt, 1'b0, s.frame_odd,
                                          (s.tx_cnt == 9'h000), s.rx_lvl};
          upc_pkg::ADDR_RXSTS:
          begin
            // popping an entry; an empty queue reads zero
            n.wb_dat = s.sq[0];
            if (s.sq_cnt != 3'h0)
            begin
              n.sq = {32'h0, s.sq[3:1]};
              n.sq_cnt = s.sq_cnt - 3'h1;
              halt_pop = (s.sq[0][31:16] == upc_pkg::STS_HALT);
              n.rx_unread = s.rx_unread || (s.sq[0][31:16] == upc_pkg::STS_IN_DATA);
            end
          end
          upc_pkg::ADDR_RXD:
          begin
            n.wb_dat = rx_q;
            if (s.rx_cnt != 9'h000)
            begin
              n.rx_rd_ptr = s.rx_rd_ptr + 8'h01;
              n.rx_cnt = s.rx_cnt - 9'h001;
              // packet drained: complete right after the last word leaves
              if (s.rx_cnt == 9'h001 && s.rx_unread)
              begin
                n.flags[upc_pkg::INT_TRANSFER_COMPLETE_FLAG] = 1'b1;
                n.rx_unread = 1'b0;
              end
            end
          end
          default: n.wb_dat = '0;
        endcase
      end
    end
    if (halt_pop)
    begin
      n.flags[upc_pkg::INT_HALT] = 1'b1;
    end
    // frame boundary; an unanswered token means the slot was missed
    if (i_sof)
    begin
      n.frame_odd = !s.frame_odd;
      n.sent_frame = 1'b0;
      if (s.st == upc_pkg::ST_WAIT)
      begin
        n.flags[upc_pkg::INT_FOVR] = 1'b1;
        n.st = upc_pkg::ST_IDLE;
      end
    end
    // one token per frame, only in the frame parity asked for
    unique case (s.st)
      upc_pkg::ST_IDLE:
      begin
        if (!i_sof && n.ch_ena && s.pq_cnt != 3'h0 && !s.sent_frame
            && s.frame_odd == s.odd_sel && (s.dir_in || s.tx_cnt >= {1'b0, s.wpp}))
        begin
          tok_fire = 1'b1;
          n.tok_req = 1'b1;
          n.tok_in = s.dir_in;
          n.sent_frame = 1'b1;
          n.tx_left = s.wpp;
          n.st = s.dir_in ? upc_pkg::ST_WAIT : upc_pkg::ST_SEND;
        end
      end
      upc_pkg::ST_SEND:
      begin
        // stream one word per cycle; data appears with tx_vld
        tx_re = 1'b1;
        n.tx_vld = 1'b1;
        n.tx_last = (s.tx_left == 8'h01);
        n.tx_rd_ptr = s.tx_rd_ptr + 8'h01;
        n.tx_cnt = n.tx_cnt - 9'h001;
        n.tx_left = s.tx_left - 8'h01;
        if (s.tx_left == 8'h01)
        begin
          n.st = upc_pkg::ST_WAIT;
        end
      end
      upc_pkg::ST_WAIT:
      begin
        // in data words land in the receive fifo
        if (s.dir_in && i_link.rx_valid && !s.rx_cnt[8])
        begin
          rx_we = 1'b1;
          n.rx_wr_ptr = s.rx_wr_ptr + 8'h01;
          n.rx_cnt = s.rx_cnt + 9'h001;
          n.rx_bytes = s.rx_bytes + upc_pkg::BYTES_PER_WORD;
          if (i_link.rx_last)
          begin
            in_push = 1'b1;
            done_push = (s.pkt_cnt == 10'h001);
            n.pkt_cnt = s.pkt_cnt - 10'h001;
            n.rx_bytes = '0;
            n.flags[upc_pkg::INT_ACK] = 1'b1;
            n.st = upc_pkg::ST_IDLE;
          end
        end
        // handshakes close the transaction
        if (i_link.hs_valid)
        begin
          n.st = upc_pkg::ST_IDLE;
          case (i_link.hs)
            upc_pkg::HS_ACK:
            begin
              n.flags[upc_pkg::INT_ACK] = 1'b1;
              if (!s.dir_in)
              begin
                n.pkt_cnt = s.pkt_cnt - 10'h001;
                if (s.pkt_cnt == 10'h001)
                begin
                  n.flags[upc_pkg::INT_TRANSFER_COMPLETE_FLAG] = 1'b1;
                  n.ch_ena = 1'b0;
                end
              end
            end
            upc_pkg::HS_NAK: n.flags[upc_pkg::INT_NAK] = 1'b1;
            upc_pkg::HS_STALL: n.flags[upc_pkg::INT_STALL] = 1'b1;
            upc_pkg::HS_XERR: n.flags[upc_pkg::INT_XERR] = 1'b1;
            upc_pkg::HS_BBL: n.flags[upc_pkg::INT_BBL] = 1'b1;
            default: n.flags[upc_pkg::INT_XERR] = 1'b1; // illegal code counts as error
          endcase
        end
      end
      default: n.st = upc_pkg::ST_IDLE; // two-bit code 11 is illegal
    endcase
    // queue bookkeeping after all sources are known
    if (tok_fire)
    begin
      n.pq_cnt = n.pq_cnt - 3'h1;
    end
    if (post_in || post_out)
    begin
      n.pq_cnt = n.pq_cnt + 3'h1;
    end
    if (in_push)
    begin
      n = sq_push(n, {upc_pkg::STS_IN_DATA, s.rx_bytes + upc_pkg::BYTES_PER_WORD});
    end
    if (done_push)
    begin
      n = sq_push(n, {upc_pkg::STS_XFER_DONE, 16'h0000});
    end
    if (halt_push)
    begin
      n = sq_push(n, {upc_pkg::STS_HALT, 16'h0000});
    end
    n.rx_lvl = (n.sq_cnt != 3'h0);
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s <= '0;
      s.wpp <= upc_pkg::WPP_RST;
    end
    else if (i_clk_en)
    begin
      s <= n;
    end
  end

  // transmit packet words
  upc_mem #(.AW(upc_pkg::MEM_AW), .DW(32)) u_tx_mem (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_we(tx_we),
    .i_waddr(s.tx_wr_ptr),
    .i_wdata(i_wb_dat),
    .i_re(tx_re),
    .i_raddr(s.tx_rd_ptr),
    .o_rdata(tx_q)
  );

  // received packet words
  upc_mem #(.AW(upc_pkg::MEM_AW), .DW(32)) u_rx_mem (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_we(rx_we),
    .i_waddr(s.rx_wr_ptr),
    .i_wdata(i_link.rx_data),
    .i_re(rx_re),
    .i_raddr(s.rx_rd_ptr),
    .o_rdata(rx_q)
  );

  // outputs, all from flops
  assign o_wb_ack = s.wb_ack;
  assign o_wb_dat = s.wb_dat;
  assign o_rx_fifo_level = s.rx_lvl;
  assign o_link = '{tok_req: s.tok_req, tok_in: s.tok_in, tx_valid: s.tx_vld,
                    tx_last: s.tx_last, tx_data: tx_q};

  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_out_done;
    i_clk_en && s.st == upc_pkg::ST_WAIT && !s.dir_in && i_link.hs_valid
    && i_link.hs == upc_pkg::HS_ACK && s.pkt_cnt == 10'h001;
  endsequence
  sequence s_in_last;
    i_clk_en && s.st == upc_pkg::ST_WAIT && s.dir_in && i_link.rx_valid && i_link.rx_last
    && !s.rx_cnt[8] && !i_sof;
  endsequence

  property p_out_post;
    (i_clk_en && post_out && !tok_fire) |=> s.pq_cnt == $past(s.pq_cnt) + 3'h1;
  endproperty
  a_out_post: assert property (p_out_post) else $error("out packet did not post request");
  property p_in_post;
    (i_clk_en && post_in && !tok_fire) |=> s.pq_cnt == $past(s.pq_cnt) + 3'h1;
  endproperty
  a_in_post: assert property (p_in_post) else $error("enable write did not post request");
  property p_out_odd;
    s.tok_req && !s.tok_in |-> s.frame_odd == s.odd_sel && s.st == upc_pkg::ST_SEND;
  endproperty
  a_out_odd: assert property (p_out_odd) else $error("out token in wrong frame");
  property p_in_odd;
    s.tok_req && s.tok_in |-> s.frame_odd == s.odd_sel && $past(s.pq_cnt) != 3'h0;
  endproperty
  a_in_odd: assert property (p_in_odd) else $error("in token in wrong frame");
  property p_out_transfer_complete_flag;
    s_out_done |=> s.flags[upc_pkg::INT_TRANSFER_COMPLETE_FLAG] && !s.ch_ena;
  endproperty
  a_out_transfer_complete_flag: assert property (p_out_transfer_complete_flag) else $error("out completion not flagged");
  property p_in_level;
    s_in_last |=> o_rx_fifo_level ##0 s.st == upc_pkg::ST_IDLE;
  endproperty
  a_in_level: assert property (p_in_level) else $error("rx level not raised");
  property p_done_entry;
    (s_in_last and (s.pkt_cnt == 10'h001 && s.sq_cnt < 3'h3 && !halt_push))
      |=> s.sq[2'(s.sq_cnt - 3'h1)][31:16] == upc_pkg::STS_XFER_DONE && o_rx_fifo_level;
  endproperty
  a_done_entry: assert property (p_done_entry) else $error("complete entry missing");
  property p_in_transfer_complete_flag;
    (i_clk_en && s.wb_busy && req && !i_wb_we && i_wb_adr == upc_pkg::ADDR_RXD
     && s.rx_cnt == 9'h001 && s.rx_unread) |=> s.flags[upc_pkg::INT_TRANSFER_COMPLETE_FLAG] && o_wb_ack;
  endproperty
  a_in_transfer_complete_flag: assert property (p_in_transfer_complete_flag) else $error("in completion not flagged");
  property p_halt_late;
    $rose(s.flags[upc_pkg::INT_HALT]) |-> $past(halt_pop) && o_wb_ack;
  endproperty
  a_halt_late: assert property (p_halt_late) else $error("halted flag before entry read");
endmodule : upc_chan

// file: testbench/upc_dev_model.sv
// upc_dev_model: far-side usb function answering the channel's tokens
// assumes the link port of upc_chan, sharing its clock
`timescale 1ns/1ps
module upc_dev_model #(
  parameter logic [31:0] DATA_BASE = 32'h0000_0100
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire upc_pkg::upc_link_out_t i_tok,
  input wire upc_pkg::upc_hs_t i_hs,
  input wire logic [7:0] i_words,
  input wire logic [3:0] i_delay,
  output upc_pkg::upc_link_in_t o_link
);
  int n = 0; // bounded wait on the out packet
  // one token at a time; idle data toggles so stale words never look valid
  initial
  begin
    o_link = '0;
    forever
    begin
      @(posedge i_core_clk);
      if (i_rst_b && i_tok.tok_req === 1'b1)
      begin
        // out: let the whole packet pass before answering
        for (n = 0; i_tok.tok_in !== 1'b1 && i_tok.tx_last !== 1'b1 && n < 300; n++)
          @(posedge i_core_clk);
        // slow answer, eight cycles per step, long enough to miss a frame
        repeat ({i_delay, 3'h0}) @(posedge i_core_clk);
        if (i_tok.tok_in === 1'b1 && i_hs == upc_pkg::HS_ACK)
        begin
          // in: one data packet, last word flagged; other codes answer a handshake
          for (int k = 0; k < i_words; k++)
          begin
            o_link.rx_valid <= 1'b1;
            o_link.rx_data <= DATA_BASE + 32'(k);
            o_link.rx_last <= (k == i_words - 1);
            @(posedge i_core_clk);
          end
          o_link.rx_valid <= 1'b0;
          o_link.rx_last <= 1'b0;
        end
        else
        begin
          // handshake pulse
          o_link.hs <= i_hs;
          o_link.hs_valid <= 1'b1;
          @(posedge i_core_clk);
          o_link.hs_valid <= 1'b0;
        end
      end
      else
        o_link.rx_data <= ~o_link.rx_data;
    end
  end
endmodule : upc_dev_model

// file: testbench/upc_chan_tb.sv
// upc_chan_tb: register-level test of the periodic channel
// assumes upc_dev_model on the link side and bench-made frame pulses
`timescale 1ns/1ps
module upc_chan_tb;
  localparam logic [31:0] RX_BASE = 32'hc0de_0000; // payload seed
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic sof = 1'b0; // frame start pulse
  logic sof_on = 1'b0; // frames may start
  logic odd_exp = 1'b0; // expected frame parity
  logic [5:0] fcnt = 6'h00;
  logic [3:0] dly = 4'h0; // device answer delay
  upc_pkg::upc_hs_t hs = upc_pkg::HS_ACK; // device handshake
  logic [31:0] tx_exp = 32'h1111_0000; // next streamed out word
  logic ack;
  logic [31:0] rdat;
  logic lvl;
  upc_pkg::upc_link_in_t lin;
  upc_pkg::upc_link_out_t lout;
  int mismatches = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  // frames of 64 cycles; when stopped, finish on an even frame
  always @(posedge clk)
  begin
    fcnt <= fcnt + 6'h01;
    sof <= (fcnt == 6'h27) && (sof_on || odd_exp);
    if (sof)
      odd_exp <= ~odd_exp;
  end
  upc_chan dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(wb_we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_sof(sof), .i_link(lin), .o_link(lout),
    .o_rx_fifo_level(lvl));
  upc_dev_model #(.DATA_BASE(RX_BASE)) dev (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_tok(lout), .i_hs(hs), .i_words(8'h02), .i_delay(dly), .o_link(lin));
  // out words leave in write order, last flag on every second word
  always @(posedge clk)
  begin
    if (lout.tx_valid === 1'b1)
    begin
      chk(lout.tx_data, tx_exp);
      chk({31'h0, lout.tx_last}, {31'h0, tx_exp[0]});
      tx_exp <= tx_exp + 32'h1;
    end
  end
  task automatic end_of_test;
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wb_we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge clk);
    if (n == 50)
    begin
      mismatches++;
      end_of_test;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // 0 token, 1 handshake, 2 rx level, 3 even frame; bounded
  task automatic wait_on(input int s);
    int n;
    logic [3:0] hit;
    for (n = 0; n < 400; n++)
    begin
      @(posedge clk);
      hit = {~odd_exp, lvl, lin.hs_valid, lout.tok_req};
      if (hit[s] === 1'b1)
        break;
    end
    if (n == 400)
    begin
      mismatches++;
      end_of_test;
    end
  endtask : wait_on
  // open frames until a token leaves, then wait on event s
  task automatic slot(input int s);
    sof_on <= 1'b1;
    wait_on(0);
    sof_on <= 1'b0;
    wait_on(s);
  endtask : slot
  // disable the channel, then pop its halt entry
  task automatic halt;
    wr(upc_pkg::ADDR_CHAR, 32'h4);
    rd(upc_pkg::ADDR_RXSTS, 32'hffff_0000, 32'h0070_0000);
  endtask : halt
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd(upc_pkg::ADDR_TSIZ, 32'hffff_ffff, 32'h0001_0000);
    rd(upc_pkg::ADDR_CHAR, 32'hffff_ffff, 32'h0);
    rd(upc_pkg::ADDR_GSTS, 32'h73, 32'h02);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'hffff_ffff, 32'h0);
    // interrupt out, one packet of two words
    wr(upc_pkg::ADDR_TSIZ, 32'h0002_0001);
    wr(upc_pkg::ADDR_CHAR, 32'h0000_0003);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0000);
    rd(upc_pkg::ADDR_GSTS, 32'h70, 32'h00);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0001);
    rd(upc_pkg::ADDR_GSTS, 32'h70, 32'h10);
    sof_on <= 1'b1;
    wait_on(0);
    chk({30'h0, odd_exp, lout.tok_in}, 32'h2);
    sof_on <= 1'b0;
    wait_on(1);
    rd(upc_pkg::ADDR_INT, 32'hff, 32'h05);
    rd(upc_pkg::ADDR_CHAR, 32'h0b, 32'h01);
    wr(upc_pkg::ADDR_INT, 32'hff);
    rd(upc_pkg::ADDR_INT, 32'hff, 32'h00);
    // periodic in, slow device
    wait_on(3);
    wr(upc_pkg::ADDR_TSIZ, 32'h0002_0001);
    wr(upc_pkg::ADDR_CHAR, 32'h0000_000b);
    rd(upc_pkg::ADDR_GSTS, 32'h70, 32'h10);
    dly <= 4'h3;
    sof_on <= 1'b1;
    wait_on(0);
    chk({30'h0, odd_exp, lout.tok_in}, 32'h3);
    sof_on <= 1'b0;
    wait_on(2);
    rd(upc_pkg::ADDR_INT, 32'h01, 32'h00);
    rd(upc_pkg::ADDR_RXSTS, 32'hffff_ffff, 32'h0010_0008);
    rd(upc_pkg::ADDR_RXD, 32'hffff_ffff, RX_BASE);
    rd(upc_pkg::ADDR_RXD, 32'hffff_ffff, RX_BASE + 32'h1);
    rd(upc_pkg::ADDR_INT, 32'h01, 32'h01);
    chk({31'h0, lvl}, 32'h1);
    rd(upc_pkg::ADDR_RXSTS, 32'hffff_0000, 32'h0030_0000);
    rd(upc_pkg::ADDR_GSTS, 32'h01, 32'h00);
    rd(upc_pkg::ADDR_TSIZ, 32'h3ff, 32'h0);
    wr(upc_pkg::ADDR_CHAR, 32'h0);
    // halt: flag only once its entry is popped
    wr(upc_pkg::ADDR_CHAR, 32'h0000_0004);
    rd(upc_pkg::ADDR_INT, 32'h02, 32'h00);
    rd(upc_pkg::ADDR_RXSTS, 32'hffff_0000, 32'h0070_0000);
    rd(upc_pkg::ADDR_INT, 32'h02, 32'h02);
    // interrupt out: nak, then stall on the retry
    wait_on(3);
    wr(upc_pkg::ADDR_INT, 32'hff);
    hs <= upc_pkg::HS_NAK;
    wr(upc_pkg::ADDR_CHAR, 32'h3);
    rd(upc_pkg::ADDR_GSTS, 32'h02, 32'h02);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0002);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0003);
    slot(1);
    rd(upc_pkg::ADDR_INT, 32'hff, 32'h08);
    halt;
    rd(upc_pkg::ADDR_INT, 32'hff, 32'h0a);
    wait_on(3);
    wr(upc_pkg::ADDR_INT, 32'hff);
    hs <= upc_pkg::HS_STALL;
    wr(upc_pkg::ADDR_CHAR, 32'h3);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0004);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0005);
    slot(1);
    rd(upc_pkg::ADDR_INT, 32'hff, 32'h10);
    halt;
    // iso in: transaction error
    wait_on(3);
    wr(upc_pkg::ADDR_INT, 32'hff);
    hs <= upc_pkg::HS_XERR;
    wr(upc_pkg::ADDR_CHAR, 32'hb);
    slot(1);
    rd(upc_pkg::ADDR_INT, 32'hff, 32'h20);
    halt;
    // iso out: device too slow, frame overrun
    wait_on(3);
    wr(upc_pkg::ADDR_INT, 32'hff);
    hs <= upc_pkg::HS_ACK;
    dly <= 4'hf;
    wr(upc_pkg::ADDR_CHAR, 32'h3);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0006);
    wr(upc_pkg::ADDR_TXD, 32'h1111_0007);
    slot(3);
    rd(upc_pkg::ADDR_INT, 32'hff, 32'h80);
    halt;
    wr(upc_pkg::ADDR_CHAR, 32'h0);
    end_of_test;
  end
endmodule : upc_chan_tb
